/* hw/pcpm_defs.svh */
// constants of the power management and extended capability register bank
// assumes byte addressing on a 32-bit avalon-mm slave port
`ifndef PCPM_DEFS_SVH
`define PCPM_DEFS_SVH

`define PCPM_ADDR_W          5
`define PCPM_OFF_PMCAP       5'h00
`define PCPM_OFF_PMCTRL      5'h04
`define PCPM_OFF_SERIAL_LO   5'h08
`define PCPM_OFF_SERIAL_HI   5'h0c
`define PCPM_OFF_EXTCAP      5'h10
`define PCPM_OFF_TCENABLE    5'h14
`define PCPM_OFF_STATUS      5'h18

// capability word fields
`define PCPM_CAP_DSI_BIT     5
`define PCPM_CAP_D1_BIT      9
`define PCPM_CAP_D2_BIT      10
`define PCPM_CAP_PME_LSB     11

// control word fields
`define PCPM_CTL_STATE_LSB   0
`define PCPM_CTL_NSR_BIT     3
`define PCPM_CTL_PMEEN_BIT   8
`define PCPM_CTL_DSEL_LSB    9
`define PCPM_CTL_SCALE_LSB   13
`define PCPM_CTL_PMEST_BIT   15
`define PCPM_CTL_DATA_LSB    24

// extended capability word fields
`define PCPM_EXT_SERIAL_BIT  0
`define PCPM_EXT_VC_BIT      1
`define PCPM_EXT_VSEC_BIT    2
`define PCPM_EXT_SNOOP_BIT   3
`define PCPM_EXT_UCFG_BIT    4
`define PCPM_EXT_PTR_LSB     8

// status word fields
`define PCPM_STS_REFUSED_BIT 0

// reset values
`define PCPM_RST_TCENABLE    8'h01
`define PCPM_RST_STATE       2'h0

// user configuration pointer limits, dword addresses
`define PCPM_UPTR_MIN        7'h2a
`define PCPM_UPTR_MAX        7'h3f

`endif

/* hw/pcpm_pkg.sv */
// types of the power management and extended capability register bank
// assumes the constants header is included by each user
package pcpm_pkg;

   typedef enum logic [1:0] {
      PCPM_D0    = 2'h0,
      PCPM_D1    = 2'h1,
      PCPM_D2    = 2'h2,
      PCPM_D3HOT = 2'h3
   } pcpm_pstate_t;

   typedef struct packed {
      logic       valid;
      logic [2:0] tc;
      logic       noSnoopApplies;
      logic       noSnoopSet;
   } pcpm_txn_t;

   typedef struct packed {
      logic valid;
      logic unsupported;
   } pcpm_verdict_t;

   typedef struct packed {
      logic prevReq;
      logic accepted;
      logic refused;
   } pcpm_wake_state_t;

   typedef struct packed {
      logic          ack;
      logic [31:0]   rdata;
      pcpm_pstate_t  pwrState;
      logic          pmeEn;
      logic          pmeStatus;
      logic [3:0]    dataSel;
      logic [7:0]    tcEnable;
      logic          wakeRefused;
      logic          pmeMsg;
      pcpm_verdict_t verdict;
      logic          cfgToUser;
   } pcpm_state_t;

endpackage

/* hw/pcpm_wake_gate.sv */
// wake request gate: passes a wake request only in pme-capable power states
// assumes powerWakeRequest is synchronous to clk and held as a level
`timescale 1ns/1ps
`include "pcpm_defs.svh"

module pcpm_wake_gate
   import pcpm_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic [3:0]   pmeSupport,
   input  wire pcpm_pstate_t pwrState,
   input  wire logic         powerWakeRequest,
   output logic              wakeAccepted,
   output logic              wakeRefused
);

   pcpm_wake_state_t state_reg;
   pcpm_wake_state_t state_next;

   always_comb begin
      logic rise;
      rise                = 1'b0;
      state_next          = state_reg;
      rise                = powerWakeRequest & ~state_reg.prevReq;
      state_next.prevReq  = powerWakeRequest;
      // one event per rising edge; a held level is not a new wake
      state_next.accepted = rise & pmeSupport[pwrState];
      state_next.refused  = rise & ~pmeSupport[pwrState];
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign wakeAccepted = state_reg.accepted;
   assign wakeRefused  = state_reg.refused;

endmodule

/* hw/pcpm_config_bank.sv */
// power management and extended capability register bank of the endpoint or, with ROOT_PORT set, the root port
// assumes an avalon-mm master on the register port, user logic on the wake,
// serial and transaction ports, all on clk
`timescale 1ns/1ps
`include "pcpm_defs.svh"

module pcpm_config_bank
   import pcpm_pkg::*;
#(
   parameter bit       DEV_SPEC_INIT  = 1'b0,
   parameter bit       D1_SUPPORT     = 1'b0,
   parameter bit       D2_SUPPORT     = 1'b0,
   parameter bit [4:0] PME_SUPPORT    = 5'h00,
   parameter bit       SERIAL_CAP_EN  = 1'b1,
   parameter bit       VC_CAP_EN      = 1'b0,
   parameter bit       VSEC_CAP_EN    = 1'b0,
   parameter bit       ROOT_PORT      = 1'b0,
   parameter bit       REJECT_SNOOP   = 1'b0,
   parameter bit       USER_CFG_EN    = 1'b0,
   parameter bit [6:0] USER_CFG_PTR   = 7'h3f
)(
   input  wire logic                    clk,
   input  wire logic                    nrst,
   input  wire logic [`PCPM_ADDR_W-1:0] avs_address,
   input  wire logic                    avs_read,
   input  wire logic                    avs_write,
   input  wire logic [31:0]             avs_writedata,
   input  wire logic [3:0]              avs_byteenable,
   output logic [31:0]                  avs_readdata,
   output logic                         avs_waitrequest,
   input  wire logic                    powerWakeRequest,
   input  wire logic [63:0]             serialIdentity,
   output logic                         pmeMessage,
   output pcpm_pstate_t                 powerState,
   input  wire pcpm_txn_t               txn,
   output pcpm_verdict_t                verdict,
   input  wire logic [6:0]              cfgDwordAddr,
   output logic                         cfgToUser
);

   // build-time checks
   if ((VC_CAP_EN || VSEC_CAP_EN) && !SERIAL_CAP_EN) begin : g_bad_ext
      $error("vc or vendor capability needs the serial capability");
   end
   if (USER_CFG_PTR < `PCPM_UPTR_MIN || USER_CFG_PTR > `PCPM_UPTR_MAX) begin : g_bad_ptr
      $error("user configuration pointer out of range");
   end
   if (REJECT_SNOOP && !ROOT_PORT) begin : g_bad_snoop
      $error("snoop rejection applies to root port only");
   end

   // d3cold wakes are signalled by auxiliary logic outside this bank
   localparam logic [3:0] PME_IN_STATE = PME_SUPPORT[3:0];

   pcpm_state_t state_reg;
   pcpm_state_t state_next;
   logic        wakeAccepted;
   logic        wakeRefused;

   pcpm_wake_gate u_wake_gate (
      .clk              (clk),
      .nrst             (nrst),
      .pmeSupport       (PME_IN_STATE),
      .pwrState         (state_reg.pwrState),
      .powerWakeRequest (powerWakeRequest),
      .wakeAccepted     (wakeAccepted),
      .wakeRefused      (wakeRefused)
   );

   function automatic logic stateSupported(input logic [1:0] s);
      stateSupported = 1'b1;
      if (s == PCPM_D1) begin
         stateSupported = D1_SUPPORT;
      end else if (s == PCPM_D2) begin
         stateSupported = D2_SUPPORT;
      end
   endfunction

   function automatic logic [31:0] capWord();
      logic [31:0] w;
      w = '0;
      w[`PCPM_CAP_DSI_BIT]                  = DEV_SPEC_INIT;
      w[`PCPM_CAP_D1_BIT]                   = D1_SUPPORT;
      w[`PCPM_CAP_D2_BIT]                   = D2_SUPPORT;
      w[`PCPM_CAP_PME_LSB +: 5]             = PME_SUPPORT;
      capWord = w;
   endfunction

   function automatic logic [31:0] extWord();
      logic [31:0] w;
      w = '0;
      w[`PCPM_EXT_SERIAL_BIT]    = SERIAL_CAP_EN;
      w[`PCPM_EXT_VC_BIT]        = VC_CAP_EN;
      w[`PCPM_EXT_VSEC_BIT]      = VSEC_CAP_EN;
      w[`PCPM_EXT_SNOOP_BIT]     = ROOT_PORT & REJECT_SNOOP;
      w[`PCPM_EXT_UCFG_BIT]      = USER_CFG_EN;
      w[`PCPM_EXT_PTR_LSB +: 7]  = USER_CFG_PTR;
      extWord = w;
   endfunction

   function automatic logic [31:0] regRead(input logic [`PCPM_ADDR_W-1:0] a, input pcpm_state_t s,
                                           input logic [63:0] sn);
      logic [31:0] w;
      w = '0;
      if (a == `PCPM_OFF_PMCAP) begin
         w = capWord();
      end else if (a == `PCPM_OFF_PMCTRL) begin
         w[`PCPM_CTL_STATE_LSB +: 2] = s.pwrState;
         w[`PCPM_CTL_NSR_BIT]        = 1'b1;
         w[`PCPM_CTL_PMEEN_BIT]      = s.pmeEn;
         w[`PCPM_CTL_DSEL_LSB +: 4]  = s.dataSel;
         w[`PCPM_CTL_SCALE_LSB +: 2] = 2'h0;
         w[`PCPM_CTL_DATA_LSB +: 8]  = 8'h00;
         w[`PCPM_CTL_PMEST_BIT]      = s.pmeStatus;
      end else if (a == `PCPM_OFF_SERIAL_LO) begin
         w = SERIAL_CAP_EN ? sn[31:0] : 32'h0000_0000;
      end else if (a == `PCPM_OFF_SERIAL_HI) begin
         w = SERIAL_CAP_EN ? sn[63:32] : 32'h0000_0000;
      end else if (a == `PCPM_OFF_EXTCAP) begin
         w = extWord();
      end else if (a == `PCPM_OFF_TCENABLE) begin
         w[7:0] = s.tcEnable;
      end else if (a == `PCPM_OFF_STATUS) begin
         w[`PCPM_STS_REFUSED_BIT] = s.wakeRefused;
      end
      regRead = w;
   endfunction

   always_comb begin
      logic doWrite;
      logic hit;
      doWrite    = 1'b0;
      hit        = 1'b0;
      state_next = state_reg;

      // one wait cycle per access: data is fetched, then handed over
      hit           = (avs_read | avs_write) & ~state_reg.ack;
      doWrite       = avs_write & state_reg.ack;
      state_next.ack = hit;
      if (hit && avs_read) begin
         state_next.rdata = regRead(avs_address, state_reg, serialIdentity);
      end

      // pme status: hardware set wins over a same-cycle clear
      if (doWrite && avs_address == `PCPM_OFF_PMCTRL) begin
         if (avs_byteenable[0] && stateSupported(avs_writedata[1:0])) begin
            // leaving d3hot keeps every field; no internal reset here
            state_next.pwrState = pcpm_pstate_t'(avs_writedata[1:0]);
         end
         if (avs_byteenable[1]) begin
            state_next.pmeEn   = avs_writedata[`PCPM_CTL_PMEEN_BIT];
            state_next.dataSel = avs_writedata[`PCPM_CTL_DSEL_LSB +: 4];
            if (avs_writedata[`PCPM_CTL_PMEST_BIT]) begin
               state_next.pmeStatus = 1'b0;
            end
         end
      end else if (doWrite && avs_address == `PCPM_OFF_TCENABLE) begin
         if (avs_byteenable[0]) begin
            // tc0 always maps to vc0 and stays enabled
            state_next.tcEnable = avs_writedata[7:0] | 8'h01;
         end
      end else if (doWrite && avs_address == `PCPM_OFF_STATUS) begin
         if (avs_byteenable[0] && avs_writedata[`PCPM_STS_REFUSED_BIT]) begin
            state_next.wakeRefused = 1'b0;
         end
      end
      if (wakeAccepted) begin
         state_next.pmeStatus = 1'b1;
      end
      if (wakeRefused) begin
         state_next.wakeRefused = 1'b1;
      end
      state_next.pmeMsg = wakeAccepted & state_reg.pmeEn;

      // transaction screening, one cycle of latency
      state_next.verdict.valid       = txn.valid;
      state_next.verdict.unsupported = txn.valid &
         ((VC_CAP_EN & ~state_reg.tcEnable[txn.tc]) |
          (ROOT_PORT & REJECT_SNOOP & txn.noSnoopApplies & ~txn.noSnoopSet));

      // requests at or above the pointer go to user logic
      state_next.cfgToUser = USER_CFG_EN & (cfgDwordAddr >= USER_CFG_PTR);
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_reg          <= '0;
         state_reg.pwrState <= pcpm_pstate_t'(`PCPM_RST_STATE);
         state_reg.tcEnable <= `PCPM_RST_TCENABLE;
      end else begin
         state_reg <= state_next;
      end
   end

   assign avs_waitrequest = (avs_read | avs_write) & ~state_reg.ack;
   assign avs_readdata    = state_reg.rdata;
   assign pmeMessage      = state_reg.pmeMsg;
   assign powerState      = state_reg.pwrState;
   assign verdict         = state_reg.verdict;
   assign cfgToUser       = state_reg.cfgToUser;

endmodule

/* dv/pcpm_config_bank_properties.sv */
// checker of the config bank port behaviour
// assumes bind onto pcpm_config_bank, one clock domain
`timescale 1ns/1ps
module pcpm_config_bank_properties
   import pcpm_pkg::*;
#(
   parameter bit [4:0] PME_SUPPORT  = 5'h00,
   parameter bit       D2_SUPPORT   = 1'b0,
   parameter bit       SNOOP_REJ    = 1'b0,
   parameter bit       USER_CFG_EN  = 1'b0,
   parameter bit [6:0] USER_CFG_PTR = 7'h3f
)(
   input wire logic          clk,
   input wire logic          nrst,
   input wire logic          avs_read,
   input wire logic          avs_write,
   input wire logic          avs_waitrequest,
   input wire logic          powerWakeRequest,
   input wire logic          pmeMessage,
   input wire pcpm_pstate_t  powerState,
   input wire pcpm_txn_t     txn,
   input wire pcpm_verdict_t verdict,
   input wire logic [6:0]    cfgDwordAddr,
   input wire logic          cfgToUser
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   a_pme_cause: assert property (pmeMessage |-> $past(powerWakeRequest, 2) && PME_SUPPORT[$past(powerState, 2)])
      else $error("pme message without capable wake");
   a_pme_single: assert property (pmeMessage |=> !pmeMessage)
      else $error("pme message longer than one cycle");
   a_no_d2_state: assert property (!D2_SUPPORT |-> powerState != PCPM_D2)
      else $error("unsupported d2 state entered");
   a_snoop_reject: assert property (SNOOP_REJ && txn.valid && txn.noSnoopApplies && !txn.noSnoopSet |=> verdict.unsupported)
      else $error("unset no snoop not rejected");
   a_verdict_timing: assert property (txn.valid |=> verdict.valid)
      else $error("verdict missing after transaction");
   a_verdict_idle: assert property (!txn.valid |=> !verdict.valid)
      else $error("verdict without transaction");
   a_tc0_passes: assert property (txn.valid && txn.tc == 3'h0 && !txn.noSnoopApplies |=> !verdict.unsupported)
      else $error("traffic class zero rejected");
   a_user_route: assert property ($past(nrst) |-> cfgToUser == (USER_CFG_EN && $past(cfgDwordAddr) >= USER_CFG_PTR))
      else $error("user config routing wrong");
   a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("more than one wait cycle");
   a_idle_nowait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("waitrequest while idle");
endmodule

bind pcpm_config_bank pcpm_config_bank_properties #(.PME_SUPPORT(PME_SUPPORT), .D2_SUPPORT(D2_SUPPORT),
   .SNOOP_REJ(ROOT_PORT && REJECT_SNOOP), .USER_CFG_EN(USER_CFG_EN), .USER_CFG_PTR(USER_CFG_PTR))
   pcpm_config_bank_properties_i (.clk(clk), .nrst(nrst), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .powerWakeRequest(powerWakeRequest), .pmeMessage(pmeMessage),
   .powerState(powerState), .txn(txn), .verdict(verdict), .cfgDwordAddr(cfgDwordAddr), .cfgToUser(cfgToUser));

/* dv/pcpm_user_model.sv */
// user logic model: wake level and serial identity
// assumes the bench raises wakeGo only where a scenario wants a wake
`timescale 1ns/1ps
module pcpm_user_model #(
   parameter logic [63:0] SERIAL_ID = 64'h0123_4567_89ab_cdef
)(
   input wire logic  clk,
   input wire logic  wakeGo,
   output logic      powerWakeRequest,
   output logic [63:0] serialIdentity
);
   logic wakeReg = 1'b0;
   // held level, low between wakes
   always @(posedge clk) begin
      wakeReg <= wakeGo;
   end
   assign powerWakeRequest = wakeReg;
   assign serialIdentity = SERIAL_ID;
endmodule

/* dv/pcpm_config_bank_test.sv */
// self-checking bench of the config bank over avalon-mm
// assumes the checker is bound to the design
`timescale 1ns/1ps
`include "pcpm_defs.svh"
module pcpm_config_bank_test;
   import pcpm_pkg::*;
   logic          clk = 1'b0;
   logic          nrst = 1'b0;
   logic [4:0]    avs_address = 5'h00;
   logic          avs_read = 1'b0;
   logic          avs_write = 1'b0;
   logic [31:0]   avs_writedata = 32'h0;
   logic [3:0]    avs_byteenable = 4'hf;
   logic [31:0]   avs_readdata;
   logic          avs_waitrequest;
   logic          wakeGo = 1'b0;
   logic          powerWakeRequest;
   logic [63:0]   serialIdentity;
   logic          pmeMessage;
   pcpm_pstate_t  powerState;
   pcpm_txn_t     txn = 6'h00;
   pcpm_verdict_t verdict;
   logic [6:0]    cfgDwordAddr = 7'h00;
   logic          cfgToUser;
   int            nMismatch = 0;
   int            nChecks = 0;
   int            cyc = 0;
   int            pmeCount = 0;

   // d0 and d3cold wake capable; d1, d2, init flag and pointer stay at their defaults
   pcpm_config_bank #(.PME_SUPPORT(5'h11), .VC_CAP_EN(1'b1), .ROOT_PORT(1'b1), .REJECT_SNOOP(1'b1),
      .USER_CFG_EN(1'b1))
      pcpm_config_bank_i (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .powerWakeRequest(powerWakeRequest), .serialIdentity(serialIdentity),
      .pmeMessage(pmeMessage), .powerState(powerState), .txn(txn), .verdict(verdict),
      .cfgDwordAddr(cfgDwordAddr), .cfgToUser(cfgToUser));
   pcpm_user_model pcpm_user_model_i (.clk(clk), .wakeGo(wakeGo), .powerWakeRequest(powerWakeRequest),
      .serialIdentity(serialIdentity));

   initial begin
      forever #2 clk = ~clk;
   end
   // generous ceiling, the run needs just over a hundred cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (pmeMessage === 1'b1) begin
         pmeCount <= pmeCount + 1;
      end
      if (cyc == 3000) begin
         nMismatch++;
         testDone();
      end
   end

   task automatic testDone();
      $display("checks %0d mismatches %0d", nChecks, nMismatch);
      if (nMismatch == 0 && nChecks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      nChecks++;
      if (seen !== exp) begin
         nMismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one access: request held until the edge with waitrequest low
   task automatic acc(input logic wrt, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_read <= !wrt;
      avs_write <= wrt;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, input logic [31:0] mask, input logic [31:0] exp, input string what);
      logic [31:0] q;
      acc(1'b0, a, 32'h0, 4'hf, q);
      chk(what, q & mask, exp);
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
      logic [31:0] q;
      acc(1'b1, a, d, be, q);
   endtask

   task automatic wake(input int expPulses);
      int base;
      base = pmeCount;
      @(posedge clk);
      wakeGo <= 1'b1;
      repeat (3) @(posedge clk);
      wakeGo <= 1'b0;
      repeat (5) @(posedge clk);
      chk("pme pulses", pmeCount - base, expPulses);
   endtask

   task automatic scr(input pcpm_txn_t t, input logic [6:0] a, input logic expU, input logic expC);
      @(posedge clk);
      txn <= t;
      cfgDwordAddr <= a;
      repeat (2) @(posedge clk);
      chk("unsupported", {31'h0, verdict.unsupported}, {31'h0, expU});
      chk("cfg to user", {31'h0, cfgToUser}, {31'h0, expC});
      txn <= 6'h00;
   endtask

   initial begin
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      rd(`PCPM_OFF_PMCAP, 32'h0000fe20, 32'h00008800, "cap");
      rd(`PCPM_OFF_PMCTRL, 32'hff00600b, 32'h00000008, "ctrl reset");
      rd(`PCPM_OFF_EXTCAP, 32'h00007f1f, 32'h00003f1b, "ext cap");
      rd(`PCPM_OFF_SERIAL_LO, 32'hffffffff, 32'h89abcdef, "serial lo");
      rd(`PCPM_OFF_SERIAL_HI, 32'hffffffff, 32'h01234567, "serial hi");
      rd(5'h1c, 32'hffffffff, 32'h0, "unmapped");
      wr(`PCPM_OFF_PMCAP, 32'h0);
      rd(`PCPM_OFF_PMCAP, 32'h0000fe20, 32'h00008800, "cap after write");
      wr(`PCPM_OFF_TCENABLE, 32'h06);
      rd(`PCPM_OFF_TCENABLE, 32'h000000ff, 32'h00000007, "tc enable");
      wr(`PCPM_OFF_PMCTRL, 32'hff006103);
      rd(`PCPM_OFF_PMCTRL, 32'hff00610b, 32'h0000010b, "ctrl d3hot");
      chk("state d3hot", {30'h0, powerState}, 32'h3);
      wake(0);
      rd(`PCPM_OFF_STATUS, 32'h1, 32'h1, "wake refused");
      wr(`PCPM_OFF_STATUS, 32'h1);
      rd(`PCPM_OFF_STATUS, 32'h1, 32'h0, "refused cleared");
      wr(`PCPM_OFF_PMCTRL, 32'h100);
      rd(`PCPM_OFF_PMCTRL, 32'hff00610b, 32'h00000108, "ctrl d0");
      rd(`PCPM_OFF_TCENABLE, 32'h000000ff, 32'h00000007, "tc kept");
      wr(`PCPM_OFF_PMCTRL, 32'h102);
      rd(`PCPM_OFF_PMCTRL, 32'h00000003, 32'h0, "d2 refused");
      wr(`PCPM_OFF_PMCTRL, 32'h101);
      // the write lands at the completing edge; look one edge later
      @(posedge clk);
      chk("d1 refused", {30'h0, powerState}, 32'h0);
      wake(1);
      rd(`PCPM_OFF_PMCTRL, 32'h00008000, 32'h00008000, "pme status");
      wr(`PCPM_OFF_PMCTRL, 32'h8100);
      rd(`PCPM_OFF_PMCTRL, 32'h00008000, 32'h0, "pme status cleared");
      wr(`PCPM_OFF_PMCTRL, 32'h0003, 4'h2);
      rd(`PCPM_OFF_PMCTRL, 32'h00000103, 32'h0, "lane 0 masked");
      scr(6'h24, 7'h3e, 1'b0, 1'b0);
      scr(6'h2c, 7'h3f, 1'b1, 1'b1);
      scr(6'h22, 7'h3f, 1'b1, 1'b1);
      testDone();
   end
endmodule
